// File: design/dss_regs.svh
// Bit layout of the serial word and the four loaded latches.
// Assumes the includer works on the 22-bit shift word, MSB first.
// Operation
// R1: Data captured on rising serial clock, 22-bit shift, MSB first.
// R2: Bits 21..2 are data, bits 1..0 are address.
// R3: Rising load strobe copies shift data into addressed latch only.
// R4: Address 00 loads second loop reference register.
// R5: Address 10 loads first loop reference register.
// R6: Address 01 loads second loop feedback register.
// R7: Address 11 loads first loop feedback register.
// R8: Second reference register gives 15-bit ratio and mode bits.
// R9: First reference register gives 15-bit ratio to its counter.
// R10: Ratio field sits at word bits 16..2, LSB at bit 2.
// R11: Controller must program reference ratios of two or more.
// R12: Bits 21..20 output select, 19 tristate, 18 high current, 17 polarity.
// R13: Feedback: 21 powerdown, 20 prescaler, 19..7 program, 6..2 swallow.
// R14: Unaddressed latches keep their contents on a load.
// R15: No readback; latch contents before first load undefined.
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH
`define DSS_WORD_W 22
`define DSS_DATA_W 20
`define DSS_ADDR_SECOND_REF 2'h0
`define DSS_ADDR_SECOND_FB 2'h1
`define DSS_ADDR_FIRST_REF 2'h2
`define DSS_ADDR_FIRST_FB 2'h3
`define DSS_RATIO_MSB 14
`define DSS_RATIO_LSB 0
`define DSS_POL_BIT 15
`define DSS_HICUR_BIT 16
`define DSS_TRI_BIT 17
`define DSS_SEL_LO_BIT 18
`define DSS_SEL_HI_BIT 19
`define DSS_PD_BIT 19
`define DSS_PRE_BIT 18
`define DSS_PROG_MSB 17
`define DSS_PROG_LSB 5
`define DSS_SWAL_MSB 4
`define DSS_SWAL_LSB 0
`endif

// File: design/dss_pkg.sv
// Types shared by the serial register bank.
// Assumes the constants header is included alongside.
package dss_pkg;
   typedef logic [19:0] dss_data_t;
   typedef logic [21:0] dss_word_t;
endpackage : dss_pkg

// File: design/dss_serial_bank.sv
// Serial-loaded register bank for a dual synthesizer.
// Assumes sclk, sdata and load_strobe come from an outside controller;
// clk is the core clock, unrelated to sclk.
`timescale 1ns/100ps
`include "dss_regs.svh"
module dss_serial_bank
   import dss_pkg::*;
(
   input wire logic clk, // Core clock, 40 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic sclk, // Serial link clock
   input wire logic sdata, // Serial data bit
   input wire logic load_strobe, // Latch load strobe
   output logic [14:0] second_ref_ratio, // Second loop reference ratio
   output logic [14:0] first_ref_ratio, // First loop reference ratio
   output logic [3:0] multifunction_output_select, // Output select
   output logic second_pump_tristate, // Second pump tristate
   output logic first_pump_tristate, // First pump tristate
   output logic second_pump_high_current, // Second pump fourfold
   output logic first_pump_high_current, // First pump fourfold
   output logic second_detector_polarity, // Second detector polarity
   output logic first_detector_polarity, // First detector polarity
   output logic second_loop_powerdown, // Second loop power-down
   output logic first_loop_powerdown, // First loop power-down
   output logic second_prescaler_select, // Second prescaler select
   output logic first_prescaler_select, // First prescaler select
   output logic [12:0] second_fb_program_count, // Second program count
   output logic [12:0] first_fb_program_count, // First program count
   output logic [4:0] second_swallow_count, // Second swallow count
   output logic [4:0] first_swallow_count // First swallow count
);
   // Link domain: shift register on sclk
   dss_word_t shift_q, shift_d;
   // Core domain: strobe sync, word capture, four latches
   logic [2:0] strobe_sync_q, strobe_sync_d;
   dss_data_t sref_q, sref_d, sfb_q, sfb_d, fref_q, fref_d, ffb_q, ffb_d;
   dss_word_t wsync1_q, wsync2_q;
   logic strobe_rise;

   // Shift in MSB first, one bit per rising serial clock
   always_comb begin
      shift_d = {shift_q[`DSS_WORD_W-2:0], sdata}; // see R1
   end

   // No reset on the link side: sclk may not run during reset
   always_ff @(posedge sclk) begin
      shift_q <= shift_d;
   end

   // The word is stable while the strobe rises, since the controller
   // stops clocking before raising it; two-stage sampling is then safe.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wsync1_q <= 22'h00_0000;
         wsync2_q <= 22'h00_0000;
      end else begin
         wsync1_q <= shift_q;
         wsync2_q <= wsync1_q;
      end
   end

   // Strobe synchroniser plus edge detect on the settled stages only
   assign strobe_rise = strobe_sync_q[1] & ~strobe_sync_q[2]; // see R3

   // Latch update: only the addressed latch changes on a strobe rise
   always_comb begin
      strobe_sync_d = {strobe_sync_q[1:0], load_strobe};
      sref_d = sref_q;
      sfb_d = sfb_q;
      fref_d = fref_q;
      ffb_d = ffb_q;
      if (strobe_rise) begin
         case (wsync2_q[1:0]) // see R2
            `DSS_ADDR_SECOND_REF: sref_d = wsync2_q[21:2]; // see R4
            `DSS_ADDR_SECOND_FB: sfb_d = wsync2_q[21:2]; // see R6
            `DSS_ADDR_FIRST_REF: fref_d = wsync2_q[21:2]; // see R5
            `DSS_ADDR_FIRST_FB: ffb_d = wsync2_q[21:2]; // see R7
            default: sref_d = sref_q;
         endcase
      end // see R14
   end

   // Latches reset to zero; software must treat them as undefined
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strobe_sync_q <= 3'h0;
         sref_q <= 20'h0_0000; // see R15
         sfb_q <= 20'h0_0000;
         fref_q <= 20'h0_0000;
         ffb_q <= 20'h0_0000;
      end else begin
         strobe_sync_q <= strobe_sync_d;
         sref_q <= sref_d;
         sfb_q <= sfb_d;
         fref_q <= fref_d;
         ffb_q <= ffb_d;
      end
   end

   // Field split; outputs are latch bits directly (no extra logic)
   assign second_ref_ratio =
      sref_q[`DSS_RATIO_MSB:`DSS_RATIO_LSB]; // see R8, R10
   assign first_ref_ratio =
      fref_q[`DSS_RATIO_MSB:`DSS_RATIO_LSB]; // see R9, R10
   assign multifunction_output_select =
      {fref_q[`DSS_SEL_HI_BIT:`DSS_SEL_LO_BIT],
       sref_q[`DSS_SEL_HI_BIT:`DSS_SEL_LO_BIT]}; // see R12
   assign second_pump_tristate = sref_q[`DSS_TRI_BIT]; // see R12
   assign first_pump_tristate = fref_q[`DSS_TRI_BIT];
   assign second_pump_high_current = sref_q[`DSS_HICUR_BIT];
   assign first_pump_high_current = fref_q[`DSS_HICUR_BIT];
   assign second_detector_polarity = sref_q[`DSS_POL_BIT];
   assign first_detector_polarity = fref_q[`DSS_POL_BIT];
   assign second_loop_powerdown = sfb_q[`DSS_PD_BIT]; // see R13
   assign first_loop_powerdown = ffb_q[`DSS_PD_BIT];
   assign second_prescaler_select = sfb_q[`DSS_PRE_BIT];
   assign first_prescaler_select = ffb_q[`DSS_PRE_BIT];
   assign second_fb_program_count = sfb_q[`DSS_PROG_MSB:`DSS_PROG_LSB];
   assign first_fb_program_count = ffb_q[`DSS_PROG_MSB:`DSS_PROG_LSB];
   assign second_swallow_count = sfb_q[`DSS_SWAL_MSB:`DSS_SWAL_LSB];
   assign first_swallow_count = ffb_q[`DSS_SWAL_MSB:`DSS_SWAL_LSB];
endmodule : dss_serial_bank

// File: sim/dss_ctrl_model.sv
// Serial controller model: shifts one 22-bit word, then strobes load.
// Assumes clk is the core clock of the bank under test.
`timescale 1ns/100ps
module dss_ctrl_model (
   input wire logic clk, // Core clock, paces the strobe
   output logic sclk, // Link clock, still between frames
   output logic sdata, // Serial bit
   output logic load_strobe // Load strobe
);
   initial begin
      sclk = 0;
      sdata = 0;
      load_strobe = 0;
   end
   // Bits change while sclk is low; released line shows inverse of last
   task automatic send(input logic [21:0] w);
      #2;
      for (int i = 21; i >= 0; i--) begin
         sdata = w[i];
         #16 sclk = 1;
         #16 sclk = 0;
      end
      sdata = ~w[0];
      repeat (4) @(posedge clk);
      #2 load_strobe = 1;
      repeat (8) @(posedge clk);
      #2 load_strobe = 0;
      repeat (4) @(posedge clk);
   endtask : send
endmodule : dss_ctrl_model

// File: sim/dss_serial_bank_monitor.sv
// Checker: shadows the link word and ties changes of selected latch fields to it.
// Assumes sclk stands still around each load.
`timescale 1ns/100ps
module dss_serial_bank_monitor (
   input logic clk,
   input logic rstn,
   input logic sclk,
   input logic sdata,
   input logic load_strobe,
   input logic [14:0] second_ref_ratio,
   input logic [14:0] first_ref_ratio,
   input logic [3:0] multifunction_output_select,
   input logic first_detector_polarity,
   input logic second_loop_powerdown,
   input logic [12:0] second_fb_program_count,
   input logic [4:0] first_swallow_count
);
   logic [21:0] sh_q;
   // Own copy of the shift word, MSB first
   always_ff @(posedge sclk) sh_q <= {sh_q[20:0], sdata};
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence strobed_s;
      $past(load_strobe, 2);
   endsequence
   load_gate_a: assert property ($changed(first_ref_ratio) ||
      $changed(second_ref_ratio) |-> strobed_s) else $error("no strobe");
   sec_ref_a: assert property ($changed(second_ref_ratio) |->
      sh_q[1:0] == 2'h0 && second_ref_ratio == sh_q[16:2]) else $error("sr");
   fst_ref_a: assert property ($changed(first_ref_ratio) |->
      sh_q[1:0] == 2'h2 && first_ref_ratio == sh_q[16:2]) else $error("fr");
   sec_fb_a: assert property ($changed(second_fb_program_count) |->
      sh_q[1:0] == 2'h1 && second_fb_program_count == sh_q[19:7])
      else $error("sb");
   fst_swal_a: assert property ($changed(first_swallow_count) |->
      sh_q[1:0] == 2'h3 && first_swallow_count == sh_q[6:2]) else $error("fa");
   out_sel_a: assert property ($changed(multifunction_output_select) |->
      !sh_q[0] && (sh_q[1] ? multifunction_output_select[3:2] :
      multifunction_output_select[1:0]) == sh_q[21:20]) else $error("sel");
   pol_a: assert property ($changed(first_detector_polarity) |->
      sh_q[1:0] == 2'h2 && first_detector_polarity == sh_q[17]) else $error("p");
   pdown_a: assert property ($changed(second_loop_powerdown) |->
      sh_q[1:0] == 2'h1 && second_loop_powerdown == sh_q[21]) else $error("pd");
endmodule : dss_serial_bank_monitor
bind dss_serial_bank dss_serial_bank_monitor dss_serial_bank_monitor_inst (.*);

// File: sim/dss_serial_bank_tb.sv
// Bench: random and corner words through the controller model.
// Assumes latches read zero after reset.
`timescale 1ns/100ps
module dss_serial_bank_tb;
   import dss_pkg::*;
   logic clk = 0, rstn = 0, sclk, sdata, ls, st, ft, sh, fh, sp, fp;
   logic sd, fd, sps, fps;
   logic [14:0] sr, fr;
   logic [3:0] sel;
   logic [12:0] sb, fb;
   logic [4:0] sa, fa;
   logic [31:0] rs = 32'h83d9_b2fe;
   dss_data_t e [4] = '{default: 0};
   int failures = 0, check_count = 0;
   dss_ctrl_model dss_ctrl_model_inst (.clk(clk), .sclk(sclk), .sdata(sdata),
      .load_strobe(ls));
   dss_serial_bank dss_serial_bank_inst (.clk(clk), .rstn(rstn), .sclk(sclk),
      .sdata(sdata), .load_strobe(ls), .second_ref_ratio(sr),
      .first_ref_ratio(fr), .multifunction_output_select(sel),
      .second_pump_tristate(st), .first_pump_tristate(ft),
      .second_pump_high_current(sh), .first_pump_high_current(fh),
      .second_detector_polarity(sp), .first_detector_polarity(fp),
      .second_loop_powerdown(sd), .first_loop_powerdown(fd),
      .second_prescaler_select(sps), .first_prescaler_select(fps),
      .second_fb_program_count(sb), .first_fb_program_count(fb),
      .second_swallow_count(sa), .first_swallow_count(fa));
   initial forever #12.5 clk = ~clk;
   task results();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task chk(input dss_data_t g, input dss_data_t x);
      check_count++;
      if (g !== x) begin
         failures++;
         $display("[ERR] %0t latch %h expected %h", $time, g, x);
      end
   endtask : chk
   // Hang guard: the whole run needs far fewer cycles
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      results();
   end
   // First four words all ones per address, then random ones
   initial begin
      dss_data_t d;
      logic [1:0] a;
      repeat (20) @(posedge clk);
      #2 rstn = 1;
      for (int n = 0; n < 28; n++) begin
         rs ^= rs << 13;
         rs ^= rs >> 17;
         rs ^= rs << 5;
         a = n < 4 ? 2'(n) : rs[1:0];
         d = n < 4 ? 20'hf_ffff : rs[31:12];
         if (!a[0] && d[14:1] == 0) d[1] = 1;
         dss_ctrl_model_inst.send({d, a});
         e[a] = d;
         chk({sel[1:0], st, sh, sp, sr}, e[0]);
         chk({sd, sps, sb, sa}, e[1]);
         chk({sel[3:2], ft, fh, fp, fr}, e[2]);
         chk({fd, fps, fb, fa}, e[3]);
      end
      results();
   end
endmodule : dss_serial_bank_tb
